// ==== rtl/uart_abd_pkg.sv ====
// constants, types and register map of the auto-baud, wake and break block
// ------------------------------------------------------------
// Summary of operation
// - sync 0x55 rising edges time divisor counter
// - enable starts calibration, receiver held idle
// - counting starts at first rise after start
// - fifth rise: keep count, self-clear, set flag
// - receive data read clears the receive flag
// - divisor pair is one 16-bit counter
// - counter advances at one eighth base rate
// - counter starts at one, not zero
// - select bits pick base and calibration clocks
// - with wake, measure byte after the break
// - overflow sets flags, counting continues
// - idle low until fifth rise; reflag after read
// - wake mode disables reception, watches falling edge
// - wake event sets receive flag at once
// - wake bit self-clears on break's rising edge
// - non-zero character: first low time wakes
// - break is start, twelve zeros, stop
// - data write with break and transmit enable bits starts break
// - break bit self-clears after stop bit
// - divisor write clears the baud timer
// ------------------------------------------------------------
package uart_abd_pkg;
    // register offsets
    localparam logic [2:0] baud_control_off = 3'h0;
    localparam logic [2:0] transmit_status_off = 3'h1;
    localparam logic [2:0] divisor_low_off = 3'h2;
    localparam logic [2:0] divisor_high_off = 3'h3;
    localparam logic [2:0] receive_data_off = 3'h4;
    localparam logic [2:0] transmit_data_off = 3'h5;
    localparam logic [2:0] flag_status_off = 3'h6;
    // baud_control_reg fields
    localparam int autobaud_enable_pos = 0;
    localparam int wake_pos = 1;
    localparam int wide_pos = 3;
    localparam int rxidle_pos = 6;
    localparam int ovf_pos = 7;
    // transmit_status_reg fields, then the flag status register bit
    localparam int shift_empty_status_pos = 1;
    localparam int hs_pos = 2;
    localparam int send_break_bit_pos = 3;
    localparam int transmit_enable_bit_pos = 5;
    localparam int rflag_pos = 0;
    // reset value, calibration start value and sync character
    localparam logic [15:0] divisor_rst = 16'h0000;
    localparam logic [15:0] abd_start_val = 16'h0001;
    localparam logic [7:0] abd_sync_char = 8'h55;
    // break shape: start plus twelve zeros low, then stop
    localparam logic [3:0] break_low_bits = 4'hd;
    localparam logic [3:0] break_last_bit = 4'he;
    localparam logic [2:0] abd_edges = 3'h5;
    localparam int sync_stages = 2;

    typedef struct packed {
        logic wide;
        logic high_speed;
        logic send_break;
        logic tx_enable;
    } ctrl_s;

    typedef enum logic [3:0] {
        abd_idle = 4'b0001,
        abd_wait_start = 4'b0010,
        abd_wait_rise = 4'b0100,
        abd_count = 4'b1000
    } abd_state_e;

    typedef enum logic [1:0] {
        tx_idle = 2'b01,
        tx_break = 2'b10
    } tx_state_e;
endpackage

// ==== rtl/uart_abd.sv ====
// auto-baud detect, wake-on-edge and break transmit logic of the serial port
`timescale 1ns/100ps
module uart_abd
    import uart_abd_pkg::*;
#(
    parameter int DIV_W = 16
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic receive_line_pin,
    output logic tx_pin,
    output logic receive_flag
);

    if (DIV_W != 16)
    begin : g_check
        $error("divisor width must be 16");
    end

    // ------------------------------------------------------------
    // reset release and receive synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    logic [sync_stages-1:0] rx_sync;
    logic rx_prev;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // first stage is read only by the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_sync <= '1;
            rx_prev <= 1'b1;
        end
        else if (ce)
        begin
            rx_sync <= {rx_sync[0], receive_line_pin};
            rx_prev <= rx_sync[1];
        end
    end

    wire rx_s = rx_sync[1];
    wire rx_rise = rx_s & ~rx_prev;
    wire rx_fall = ~rx_s & rx_prev;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    ctrl_s ctrl;
    logic autobaud_enable;
    logic wake_on_edge_enable;
    logic autobaud_overflow_flag;
    logic [15:0] divisor_counter;
    abd_state_e abd_state;
    tx_state_e tx_state;
    logic [2:0] rise_cnt;
    logic wake_armed;

    wire wr_bctl = wr && addr == baud_control_off;
    wire wr_tsta = wr && addr == transmit_status_off;
    wire wr_dlo = wr && addr == divisor_low_off;
    wire wr_dhi = wr && addr == divisor_high_off;
    wire wr_tdat = wr && addr == transmit_data_off;
    wire rd_rdat = rd && addr == receive_data_off;
    wire wr_div = wr_dlo | wr_dhi;

    wire receive_idle_status = abd_state == abd_idle && !wake_armed;
    wire shift_empty_status = tx_state == tx_idle;

    wire [7:0] bctl_view = {autobaud_overflow_flag, receive_idle_status, 2'b00,
        ctrl.wide, 1'b0, wake_on_edge_enable, autobaud_enable};
    wire [7:0] tsta_view = {2'b00, ctrl.tx_enable, 1'b0, ctrl.send_break,
        ctrl.high_speed, shift_empty_status, 1'b0};

    logic [7:0] next_rdata;
    always_comb
    begin
        case (addr)
            baud_control_off: next_rdata = bctl_view;
            transmit_status_off: next_rdata = tsta_view;
            divisor_low_off: next_rdata = divisor_counter[7:0];
            divisor_high_off: next_rdata = divisor_counter[15:8];
            flag_status_off: next_rdata = {7'h00, receive_flag};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (ce)
            rdata <= rd ? next_rdata : 8'h00;
    end

    // ------------------------------------------------------------
    // baud generator prescale
    // ------------------------------------------------------------
    function automatic logic [8:0] base_mask(input logic wide, input logic hs);
        case ({wide, hs})
            2'b00: base_mask = 9'h03f;
            2'b11: base_mask = 9'h003;
            default: base_mask = 9'h00f;
        endcase
    endfunction

    logic [8:0] pre;
    logic [15:0] baud_timer;
    wire [8:0] bmask = base_mask(ctrl.wide, ctrl.high_speed);
    wire [8:0] amask = {bmask[5:0], 3'b111};
    wire base_tick = (pre & bmask) == bmask;
    wire abd_tick = (pre & amask) == amask;
    wire [15:0] div_eff = ctrl.wide ? divisor_counter : {8'h00, divisor_counter[7:0]};
    wire bit_tick = base_tick && baud_timer == 16'h0000;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre <= 9'h000;
            baud_timer <= 16'h0000;
        end
        else if (ce)
        begin
            if (wr_div)
            begin
                pre <= 9'h000;
                baud_timer <= 16'h0000;
            end
            else
            begin
                pre <= pre + 9'h001;
                if (base_tick)
                    baud_timer <= baud_timer == 16'h0000 ? div_eff : baud_timer - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // auto-baud and wake state
    // ------------------------------------------------------------
    // measurement waits while a wake break is still pending
    wire abd_go = autobaud_enable && !wake_on_edge_enable;
    wire abd_done = abd_state == abd_count && rx_rise && rise_cnt == abd_edges - 3'h1;
    wire abd_ovf = abd_state == abd_count && abd_tick && divisor_counter == 16'hffff;
    wire wake_event = wake_on_edge_enable && !wake_armed && rx_fall;
    wire wake_end = wake_on_edge_enable && wake_armed && rx_rise;

    abd_state_e next_abd_state;
    always_comb
    begin
        case (abd_state)
            abd_idle: next_abd_state = abd_go ? abd_wait_start : abd_idle;
            abd_wait_start: next_abd_state = rx_fall ? abd_wait_rise : abd_wait_start;
            abd_wait_rise: next_abd_state = rx_rise ? abd_count : abd_wait_rise;
            abd_count: next_abd_state = abd_done ? abd_idle : abd_count;
            default: next_abd_state = abd_idle;
        endcase
        if (!autobaud_enable)
            next_abd_state = abd_idle;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            abd_state <= abd_idle;
            rise_cnt <= 3'h0;
        end
        else if (ce)
        begin
            abd_state <= next_abd_state;
            if (abd_state == abd_wait_rise)
                rise_cnt <= 3'h1;
            else if (abd_state == abd_count && rx_rise)
                rise_cnt <= rise_cnt + 3'h1;
        end
    end

    // hardware count outranks a software write of the divisor pair
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            divisor_counter <= divisor_rst;
        else if (ce)
        begin
            if (abd_state == abd_wait_rise && rx_rise)
                divisor_counter <= abd_start_val;
            else if (abd_state == abd_count && abd_tick && !abd_done)
                divisor_counter <= divisor_counter + 16'h0001;
            else if (wr_dlo)
                divisor_counter[7:0] <= wdata;
            else if (wr_dhi)
                divisor_counter[15:8] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            autobaud_enable <= 1'b0;
            wake_on_edge_enable <= 1'b0;
            autobaud_overflow_flag <= 1'b0;
            wake_armed <= 1'b0;
        end
        else if (ce)
        begin
            if (abd_done)
                autobaud_enable <= 1'b0;
            else if (wr_bctl)
                autobaud_enable <= wdata[autobaud_enable_pos];
            if (wake_end)
                wake_on_edge_enable <= 1'b0;
            else if (wr_bctl)
                wake_on_edge_enable <= wdata[wake_pos];
            if (abd_ovf)
                autobaud_overflow_flag <= 1'b1;
            else if (wr_bctl && !wdata[ovf_pos])
                autobaud_overflow_flag <= 1'b0;
            // any low time wakes, even a non-zero character's
            if (wake_event)
                wake_armed <= 1'b1;
            else if (wake_end || !wake_on_edge_enable)
                wake_armed <= 1'b0;
        end
    end

    // set wins over the read that clears
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            receive_flag <= 1'b0;
        else if (ce)
        begin
            if (abd_done || abd_ovf || wake_event)
                receive_flag <= 1'b1;
            else if (rd_rdat)
                receive_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // break transmitter
    // ------------------------------------------------------------
    logic [3:0] bit_idx;
    wire tx_start = wr_tdat && ctrl.send_break && ctrl.tx_enable;
    wire tx_end = tx_state == tx_break && bit_tick && bit_idx == break_last_bit - 4'h1;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state <= tx_idle;
            bit_idx <= 4'h0;
            tx_pin <= 1'b1;
            ctrl.wide <= 1'b0;
            ctrl.high_speed <= 1'b0;
            ctrl.send_break <= 1'b0;
            ctrl.tx_enable <= 1'b0;
        end
        else if (ce)
        begin
            case (tx_state)
                tx_idle:
                    if (tx_start && shift_empty_status)
                    begin
                        tx_state <= tx_break;
                        bit_idx <= 4'h0;
                    end
                tx_break:
                    if (tx_end)
                        tx_state <= tx_idle;
                    else if (bit_tick)
                        bit_idx <= bit_idx + 4'h1;
                default: tx_state <= tx_idle;
            endcase
            tx_pin <= !(tx_state == tx_break && bit_idx < break_low_bits);
            // whole control struct has one writer process
            if (wr_bctl)
                ctrl.wide <= wdata[wide_pos];
            if (wr_tsta)
            begin
                ctrl.high_speed <= wdata[hs_pos];
                ctrl.tx_enable <= wdata[transmit_enable_bit_pos];
            end
            if (tx_end)
                ctrl.send_break <= 1'b0;
            else if (wr_tsta)
                ctrl.send_break <= wdata[send_break_bit_pos];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_done_self_clear: assert property (@(posedge clock) disable iff (!rst_n)
        ce && abd_done |=> !autobaud_enable && receive_flag && receive_idle_status)
        else $error("calibration end did not clear enable and set flag");
    a_count_from_one: assert property (@(posedge clock) disable iff (!rst_n)
        ce && abd_state == abd_wait_rise && rx_rise |=> divisor_counter == 16'h0001)
        else $error("calibration count did not start at one");
    a_overflow_flags: assert property (@(posedge clock) disable iff (!rst_n)
        ce && abd_ovf |=> autobaud_overflow_flag && receive_flag && divisor_counter == 16'h0000)
        else $error("overflow did not set flags or wrap");
    a_read_clears_flag: assert property (@(posedge clock) disable iff (!rst_n)
        ce && rd_rdat && !(abd_done || abd_ovf || wake_event) |=> !receive_flag)
        else $error("receive data read did not clear flag");
    a_wake_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
        ce && wake_event |=> receive_flag && wake_armed)
        else $error("wake edge did not set receive flag");
    a_wake_self_clear: assert property (@(posedge clock) disable iff (!rst_n)
        ce && wake_end |=> !wake_on_edge_enable && receive_idle_status)
        else $error("wake bit did not clear at break end");
    a_abd_waits_wake: assert property (@(posedge clock) disable iff (!rst_n)
        ce && wake_on_edge_enable && abd_state == abd_idle |=> abd_state == abd_idle)
        else $error("measurement started during wake break");
    a_break_low_start: assert property (@(posedge clock) disable iff (!rst_n)
        ce && tx_state == tx_idle && tx_start ##1 ce |=> !tx_pin && !shift_empty_status)
        else $error("break did not drive line low");
    a_break_end_clear: assert property (@(posedge clock) disable iff (!rst_n)
        ce && tx_end |=> !ctrl.send_break && shift_empty_status)
        else $error("break end did not clear send bit");
    a_div_write_timer: assert property (@(posedge clock) disable iff (!rst_n)
        ce && wr_div |=> baud_timer == 16'h0000 && pre == 9'h000)
        else $error("divisor write did not clear timer");
    a_abd_tick_rate: assert property (@(posedge clock) disable iff (!rst_n)
        abd_tick |-> base_tick)
        else $error("calibration clock not aligned to base clock");
endmodule

// ==== dv/serial_node.sv ====
// remote serial node: drives the receive line and times the transmit line
`timescale 1ns/100ps
module serial_node
(
    input wire logic clock,
    input wire logic tx_pin,
    output logic rx_line
);
    // idle level of an asynchronous line is high
    initial
    begin
        rx_line = 1'b1;
    end

    // ------------------------------------------------------------
    // receive line drive
    // ------------------------------------------------------------
    task automatic hold(input logic level, input int cycles);
        @(posedge clock);
        rx_line <= level;
        repeat (cycles - 1) @(posedge clock);
    endtask

    // start bit, eight data bits least significant first, stop bit
    task automatic send_byte(input logic [7:0] b, input int bit_cycles);
        hold(1'b0, bit_cycles);
        for (int i = 0; i < 8; i++)
            hold(b[i], bit_cycles);
        hold(1'b1, bit_cycles);
    endtask

    // ------------------------------------------------------------
    // transmit line timing
    // ------------------------------------------------------------
    // bounded waits so a silent line cannot hang the run
    task automatic measure_low(output int n);
        int guard;
        n = 0;
        guard = 0;
        while (tx_pin !== 1'b0 && guard < 100)
        begin
            @(posedge clock);
            guard++;
        end
        while (tx_pin === 1'b0 && n < 1000)
        begin
            @(posedge clock);
            n++;
        end
    endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the auto-baud, wake and break block
`timescale 1ns/100ps
module tb_top;
    import uart_abd_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    logic receive_line_pin;
    logic tx_pin;
    logic receive_flag;
    logic [7:0] exp_q[$];
    int tol_q[$];
    logic [2:0] adr_q[$];
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h5060;
    int low_n;
    logic [7:0] rst_tab[8] = '{8'h40, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // each mode gives a count of 17 except one that needs the high byte
    logic [1:0] mode_tab[4] = '{2'b00, 2'b01, 2'b10, 2'b11};
    int bit_tab[4] = '{1024, 4096, 256, 64};
    logic [15:0] cnt_tab[4] = '{16'h0011, 16'h0101, 16'h0011, 16'h0011};

    always #25 clock = ~clock;

    uart_abd #(.DIV_W(16)) uart_abd_i (.clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .receive_line_pin(receive_line_pin), .tx_pin(tx_pin),
        .receive_flag(receive_flag));

    serial_node serial_node_i (.clock(clock), .tx_pin(tx_pin), .rx_line(receive_line_pin));

    // ------------------------------------------------------------
    // bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input int tol);
        adr_q.push_back(a);
        exp_q.push_back(e);
        tol_q.push_back(tol);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
    endtask

    // tolerance covers the phase of the calibration tick at both edges
    task automatic cmp_read(input logic [2:0] a, input logic [7:0] e, input int tol, input logic [7:0] s);
        logic ok;
        ok = (s === e);
        if (!ok && tol > 0 && ^s !== 1'bx)
            ok = (int'(s) - int'(e) <= tol) && (int'(e) - int'(s) <= tol);
        n_compared++;
        if (!ok)
        begin
            $display("unexpected rdata at offset %0d expected %h seen %h", a, e, s);
            bad_count++;
        end
    endtask

    task automatic chk(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e)
        begin
            $display("unexpected %s expected %b seen %b", nm, e, s);
            bad_count++;
        end
    endtask

    task automatic chk_range(input string nm, input int lo, input int hi, input int s);
        n_compared++;
        if (s < lo || s > hi)
        begin
            $display("unexpected %s expected %0d to %0d seen %0d", nm, lo, hi, s);
            bad_count++;
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // read data watcher and timeout
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        rd_q <= rd;
        if (rd_q === 1'b1 && exp_q.size() > 0)
            cmp_read(adr_q.pop_front(), exp_q.pop_front(), tol_q.pop_front(), rdata);
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 100000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (5) @(posedge clock);
        chk("receive_flag", 1'b0, receive_flag);
        chk("tx_pin", 1'b1, tx_pin);
        wr_reg(3'h7, 8'($random(seed)));
        for (int i = 0; i < 8; i++)
            if (i != 5)
                rd_reg(3'(i), rst_tab[i], 0);
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(transmit_status_off, 8'(mode_tab[m][0]) << hs_pos);
            wr_reg(baud_control_off, (8'(mode_tab[m][1]) << wide_pos) | 8'h01);
            rd_reg(baud_control_off, (8'(mode_tab[m][1]) << wide_pos) | 8'h01, 0);
            serial_node_i.send_byte(abd_sync_char, bit_tab[m]);
            chk("receive_flag", 1'b1, receive_flag);
            rd_reg(baud_control_off, (8'(mode_tab[m][1]) << wide_pos) | 8'h40, 0);
            rd_reg(divisor_low_off, cnt_tab[m][7:0], 1);
            rd_reg(divisor_high_off, cnt_tab[m][15:8], 0);
            rd_reg(receive_data_off, 8'h00, 0);
            repeat (2) @(posedge clock);
            chk("receive_flag", 1'b0, receive_flag);
        end
        // wake then calibrate on the byte after the break
        rd_reg(baud_control_off, 8'h48, 0);
        wr_reg(baud_control_off, 8'h0b);
        serial_node_i.hold(1'b0, 20);
        chk("receive_flag", 1'b1, receive_flag);
        rd_reg(receive_data_off, 8'h00, 0);
        serial_node_i.hold(1'b0, 13 * 64 - 22);
        chk("receive_flag", 1'b0, receive_flag);
        serial_node_i.hold(1'b1, 64);
        rd_reg(baud_control_off, 8'h09, 0);
        serial_node_i.send_byte(abd_sync_char, 64);
        chk("receive_flag", 1'b1, receive_flag);
        rd_reg(baud_control_off, 8'h48, 0);
        rd_reg(divisor_low_off, 8'h11, 1);
        rd_reg(divisor_high_off, 8'h00, 0);
        rd_reg(receive_data_off, 8'h00, 0);
        // data write without the break bit leaves the line idle
        wr_reg(transmit_status_off, 8'h24);
        wr_reg(transmit_data_off, 8'($random(seed)));
        repeat (10) @(posedge clock);
        chk("tx_pin", 1'b1, tx_pin);
        wr_reg(divisor_low_off, 8'h03);
        wr_reg(divisor_high_off, 8'h00);
        wr_reg(baud_control_off, 8'h08);
        wr_reg(transmit_status_off, 8'h2c);
        rd_reg(transmit_status_off, 8'h2e, 0);
        wr_reg(transmit_data_off, 8'($random(seed)));
        rd_reg(transmit_status_off, 8'h2c, 0);
        serial_node_i.measure_low(low_n);
        // bit is four base ticks of four clocks; first bit may be short
        chk_range("break_low", 12 * 16, 13 * 16 + 1, low_n);
        repeat (40) @(posedge clock);
        rd_reg(transmit_status_off, 8'h26, 0);
        chk("tx_pin", 1'b1, tx_pin);
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule
